//--- pkg/limit_pkg.sv
// package of constants and types for the current and speed limit stage
package limit_pkg;

  // ----------------------------------------------------------------
  // parameter addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_SPEED_CEIL = 16'h0612;
  localparam logic [15:0] ADDR_STAND_PCT = 16'h1414;
  localparam logic [15:0] ADDR_RAMP_PCT = 16'h1416;
  localparam logic [15:0] ADDR_CRUISE_PCT = 16'h1418;

  // ----------------------------------------------------------------
  // reset values and legal ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_SPEED_CEIL = 16'h3390;
  localparam logic [15:0] RST_STAND_PCT = 16'h0046;
  localparam logic [15:0] RST_RAMP_PCT = 16'h0064;
  localparam logic [15:0] RST_CRUISE_PCT = 16'h0064;
  localparam logic [15:0] PCT_MIN = 16'h0001;
  localparam logic [15:0] PCT_MAX = 16'h0064;
  localparam logic [15:0] SPEED_MIN = 16'h003C;
  localparam logic [15:0] SPEED_MAX = 16'h3390;

  // ----------------------------------------------------------------
  // operating mode codes (16-bit signed)
  // ----------------------------------------------------------------
  localparam logic [15:0] MODE_JOG = 16'hFFFF;
  localparam logic [15:0] MODE_PROF_POS = 16'h0001;
  localparam logic [15:0] MODE_PROF_VEL = 16'h0003;
  localparam logic [15:0] MODE_HOMING = 16'h0006;
  localparam logic [15:0] MODE_CSP = 16'h0008;

  // ----------------------------------------------------------------
  // motion phase and nonvolatile copy state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_REST = 2'b00,
    PH_RAMP = 2'b01,
    PH_CRUISE = 2'b11
  } phase_t;

  typedef enum logic [1:0] {
    NV_IDLE = 2'b00,
    NV_COPY = 2'b01,
    NV_DONE = 2'b11
  } nv_state_t;

  localparam int NV_WORDS = 4;
  localparam logic [1:0] NV_LAST = 2'h3;

endpackage

//--- pkg/nv_if.sv
// interface between the limit stage and its nonvolatile store
`timescale 1ns/100ps
`default_nettype none
interface nv_if;
  logic we; // write strobe, held high for the four copy cycles
  logic [1:0] waddr; // word index
  logic [15:0] wdata; // word to keep
  logic [1:0] raddr; // read index
  logic [15:0] rdata; // registered read data
  modport master (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

//--- rtl/nv_store.sv
// small word store standing in for the nonvolatile parameter memory
`timescale 1ns/100ps
`default_nettype none
module nv_store
(
  input wire logic i_mclk,
  input wire logic i_ce,
  nv_if.store nv
);
  // storage array, no reset: its contents model persistence
  logic [15:0] mem_q [0:limit_pkg::NV_WORDS-1];

  // ----------------------------------------------------------------
  // write port
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_ce && nv.we)
    begin
      mem_q[nv.waddr] <= nv.wdata;
    end
  end

  // ----------------------------------------------------------------
  // registered read port
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk)
  begin
    if (i_ce)
    begin
      nv.rdata <= mem_q[nv.raddr];
    end
  end
endmodule
`default_nettype wire

//--- rtl/motor_limits.sv
// current and speed limit stage of the integrated drive
`timescale 1ns/100ps
`default_nettype none
module motor_limits
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // parameter access port
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_save,
  input wire logic i_pass_restore,
  output logic [15:0] o_rdata,
  output logic o_ack,
  output logic o_err,
  output logic o_save_busy,
  output logic o_pass_is_default,
  // drive state
  input wire logic i_stage_on,
  input wire logic i_moving,
  input wire logic i_accel,
  input wire logic [15:0] i_mode,
  input wire logic [15:0] i_ref_speed,
  input wire logic [15:0] i_nominal_motor_current,
  input wire logic i_pass_change,
  // limit outputs
  output logic [15:0] o_speed_cmd,
  output logic [15:0] o_current_limit,
  output logic [1:0] o_phase
);

  // ----------------------------------------------------------------
  // working storage
  // ----------------------------------------------------------------
  logic [15:0] stand_q; // standstill percent
  logic [15:0] ramp_q; // ramp percent
  logic [15:0] cruise_q; // cruise percent
  logic [15:0] ceil_q; // written speed ceiling
  logic [15:0] ceil_act_q; // ceiling in force for this motion
  logic moving_q; // previous moving level, for start detect
  limit_pkg::phase_t phase_q; // present motion phase
  limit_pkg::nv_state_t nv_q; // save sequencer
  logic [1:0] nv_idx_q; // word being saved
  logic [15:0] nv_word; // word selected for saving

  // write qualifiers, mode decode and scaled current
  logic pct_ok;
  logic spd_ok;
  logic hit_stand;
  logic hit_ramp;
  logic hit_cruise;
  logic hit_ceil;
  logic mode_profile;
  logic [31:0] scaled;

  nv_if nvb ();

  // ----------------------------------------------------------------
  // decode and range checks
  // ----------------------------------------------------------------
  always_comb
  begin
    hit_stand = (i_addr == limit_pkg::ADDR_STAND_PCT);
    hit_ramp = (i_addr == limit_pkg::ADDR_RAMP_PCT);
    hit_cruise = (i_addr == limit_pkg::ADDR_CRUISE_PCT);
    hit_ceil = (i_addr == limit_pkg::ADDR_SPEED_CEIL);
    pct_ok = (i_wdata >= limit_pkg::PCT_MIN) && (i_wdata <= limit_pkg::PCT_MAX);
    spd_ok = (i_wdata >= limit_pkg::SPEED_MIN) && (i_wdata <= limit_pkg::SPEED_MAX);
  end

  // ----------------------------------------------------------------
  // current percent registers, effective immediately
  // ----------------------------------------------------------------
  // writes act at once
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      stand_q <= limit_pkg::RST_STAND_PCT;
      ramp_q <= limit_pkg::RST_RAMP_PCT;
      cruise_q <= limit_pkg::RST_CRUISE_PCT;
    end
    else if (i_ce && i_wr && pct_ok)
    begin
      if (hit_stand)
        stand_q <= i_wdata;
      if (hit_ramp)
        ramp_q <= i_wdata;
      if (hit_cruise)
        cruise_q <= i_wdata;
    end
  end

  // ----------------------------------------------------------------
  // speed ceiling register
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      ceil_q <= limit_pkg::RST_SPEED_CEIL;
    else if (i_ce && i_wr && hit_ceil && spd_ok && !i_stage_on)
      ceil_q <= i_wdata;
  end

  // ----------------------------------------------------------------
  // active ceiling, taken at movement start
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      ceil_act_q <= limit_pkg::RST_SPEED_CEIL;
      moving_q <= 1'b0;
    end
    else if (i_ce)
    begin
      moving_q <= i_moving;
      if (i_moving && !moving_q)
        ceil_act_q <= ceil_q;
    end
  end

  // ----------------------------------------------------------------
  // bus answer: read data, ack and error flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rdata <= 16'h0000;
      o_ack <= 1'b0;
      o_err <= 1'b0;
    end
    else if (i_ce)
    begin
      o_ack <= i_wr || i_rd;
      o_err <= 1'b0;
      if (i_rd)
      begin
        // unmapped addresses read zero and flag an error
        if (hit_stand)
          o_rdata <= stand_q;
        else if (hit_ramp)
          o_rdata <= ramp_q;
        else if (hit_cruise)
          o_rdata <= cruise_q;
        else if (hit_ceil)
          o_rdata <= ceil_q;
        else
        begin
          o_rdata <= 16'h0000;
          o_err <= 1'b1;
        end
      end
      else if (i_wr)
      begin
        if ((hit_stand || hit_ramp || hit_cruise) && !pct_ok)
          o_err <= 1'b1;
        else if (hit_ceil && (!spd_ok || i_stage_on))
          o_err <= 1'b1;
        else if (!(hit_stand || hit_ramp || hit_cruise || hit_ceil))
          o_err <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // motion phase
  // ----------------------------------------------------------------
  // phase from motion inputs
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      phase_q <= limit_pkg::PH_REST;
    else if (i_ce)
    begin
      case ({i_moving, i_accel})
        2'b10: phase_q <= limit_pkg::PH_CRUISE;
        2'b11: phase_q <= limit_pkg::PH_RAMP;
        2'b01: phase_q <= limit_pkg::PH_RAMP;
        default: phase_q <= limit_pkg::PH_REST;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // current ceiling: percent times nominal current over 100
  // ----------------------------------------------------------------
  always_comb
  begin
    case (phase_q)
      limit_pkg::PH_REST: scaled = stand_q * i_nominal_motor_current;
      limit_pkg::PH_RAMP: scaled = ramp_q * i_nominal_motor_current;
      limit_pkg::PH_CRUISE: scaled = cruise_q * i_nominal_motor_current;
      default: scaled = stand_q * i_nominal_motor_current;
    endcase
  end

  // divider is a constant; synthesis folds it into a multiply
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_current_limit <= 16'h0000;
      o_phase <= 2'b00;
    end
    else if (i_ce)
    begin
      o_current_limit <= 16'(scaled / 32'(limit_pkg::PCT_MAX));
      o_phase <= phase_q;
    end
  end

  // ----------------------------------------------------------------
  // reference speed clamp
  // ----------------------------------------------------------------
  always_comb
  begin
    case (i_mode)
      limit_pkg::MODE_JOG, limit_pkg::MODE_PROF_POS,
      limit_pkg::MODE_PROF_VEL, limit_pkg::MODE_HOMING: mode_profile = 1'b1;
      default: mode_profile = 1'b0; // cyclic and reserved pass through
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_speed_cmd <= 16'h0000;
    else if (i_ce)
    begin
      if (mode_profile && (i_ref_speed > ceil_act_q))
        o_speed_cmd <= ceil_act_q;
      else
        o_speed_cmd <= i_ref_speed;
    end
  end

  // ----------------------------------------------------------------
  // web password default flag
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_pass_is_default <= 1'b1;
    else if (i_ce)
    begin
      if (i_pass_restore)
        o_pass_is_default <= 1'b1;
      else if (i_pass_change)
        o_pass_is_default <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // save sequencer: copies four words to the store
  // ----------------------------------------------------------------
  always_comb
  begin
    case (nv_idx_q)
      2'h0: nv_word = stand_q;
      2'h1: nv_word = ramp_q;
      2'h2: nv_word = cruise_q;
      default: nv_word = ceil_q;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      nv_q <= limit_pkg::NV_IDLE;
      nv_idx_q <= 2'h0;
      o_save_busy <= 1'b0;
    end
    else if (i_ce)
    begin
      case (nv_q)
        limit_pkg::NV_IDLE:
        begin
          nv_idx_q <= 2'h0;
          if (i_save)
          begin
            nv_q <= limit_pkg::NV_COPY;
            o_save_busy <= 1'b1;
          end
        end
        limit_pkg::NV_COPY:
        begin
          nv_idx_q <= nv_idx_q + 2'h1;
          if (nv_idx_q == limit_pkg::NV_LAST)
            nv_q <= limit_pkg::NV_DONE;
        end
        limit_pkg::NV_DONE:
        begin
          nv_q <= limit_pkg::NV_IDLE;
          o_save_busy <= 1'b0;
        end
        default: nv_q <= limit_pkg::NV_IDLE;
      endcase
    end
  end

  assign nvb.we = (nv_q == limit_pkg::NV_COPY);
  assign nvb.waddr = nv_idx_q;
  assign nvb.wdata = nv_word;
  assign nvb.raddr = 2'h0;

  nv_store nv_store_i
  (
    .i_mclk(i_mclk),
    .i_ce(i_ce),
    .nv(nvb)
  );
endmodule
`default_nettype wire

//--- test/param_master.sv
// fieldbus master model that writes, reads and saves drive parameters
`timescale 1ns/100ps
`default_nettype none
module param_master
(
  input wire logic i_mclk,
  output logic o_wr,
  output logic o_rd,
  output logic o_save,
  output logic [15:0] o_addr,
  output logic [15:0] o_wdata
);
  // bus idle from time zero
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_save = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 16'h0000;
  end

  // one access held over one edge, then a free cycle so pulses never merge
  task automatic access(input logic r, input logic [15:0] a, input logic [15:0] d);
  begin
    o_rd = r;
    o_wr = !r;
    o_addr = a;
    o_wdata = d;
    @(posedge i_mclk);
    #1;
    o_rd = 1'b0;
    o_wr = 1'b0;
    // released data line shows a changed value, not the stale word
    o_wdata = ~d;
    @(posedge i_mclk);
    #1;
  end
  endtask

  task automatic save();
  begin
    o_save = 1'b1;
    @(posedge i_mclk);
    #1;
    o_save = 1'b0;
    @(posedge i_mclk);
    #1;
  end
  endtask
endmodule
`default_nettype wire

//--- test/motor_limits_properties.sv
// assertions on the ports of the limit stage
`timescale 1ns/100ps
`default_nettype none
module motor_limits_properties
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_save,
  input wire logic i_pass_restore,
  input wire logic i_stage_on,
  input wire logic i_accel,
  input wire logic [15:0] i_mode,
  input wire logic [15:0] i_ref_speed,
  input wire logic o_ack,
  input wire logic o_err,
  input wire logic o_save_busy,
  input wire logic o_pass_is_default,
  input wire logic [15:0] o_speed_cmd,
  input wire logic [1:0] o_phase
);
  // one clock domain; reset aborts every check
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  // ------------------------------
  // access answers
  // ------------------------------
  property p_ack;
    i_ce && (i_wr || i_rd) |=> o_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  property p_err_ack;
    o_err |-> o_ack;
  endproperty
  a_err_ack: assert property (p_err_ack) else $error("error without answer");
  property p_pct;
    i_ce && i_wr && !i_rd && i_addr == limit_pkg::ADDR_STAND_PCT
      && (i_wdata == 16'h0000 || i_wdata > limit_pkg::PCT_MAX) |=> o_err;
  endproperty
  a_pct: assert property (p_pct) else $error("bad percent accepted");
  property p_lock;
    i_ce && i_wr && !i_rd && i_stage_on && i_addr == limit_pkg::ADDR_SPEED_CEIL |=> o_err;
  endproperty
  a_lock: assert property (p_lock) else $error("ceiling written with stage on");
  // ------------------------------
  // speed, phase, password, save
  // ------------------------------
  property p_clamp;
    i_ce && i_mode == limit_pkg::MODE_PROF_POS |=> o_speed_cmd <= limit_pkg::SPEED_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("speed above ceiling");
  property p_thru;
    i_ce && i_mode == limit_pkg::MODE_CSP |=> o_speed_cmd == $past(i_ref_speed);
  endproperty
  a_thru: assert property (p_thru) else $error("cyclic mode speed altered");
  property p_ramp;
    (i_ce && i_accel) [*2] |=> o_phase == limit_pkg::PH_RAMP;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp phase missing");
  property p_restore;
    i_ce && i_pass_restore |=> o_pass_is_default;
  endproperty
  a_restore: assert property (p_restore) else $error("password not restored");
  property p_save;
    i_ce && i_save && !o_save_busy |=> o_save_busy ##[1:8] !o_save_busy;
  endproperty
  a_save: assert property (p_save) else $error("save not run");
  // main scenarios reached
  c_err: cover property (o_err);
  c_ramp: cover property (o_phase == limit_pkg::PH_RAMP);
  c_save: cover property ($fell(o_save_busy));
endmodule
bind motor_limits motor_limits_properties motor_limits_properties_i (.i_mclk, .i_rst,
  .i_ce, .i_wr, .i_rd, .i_addr, .i_wdata, .i_save, .i_pass_restore, .i_stage_on,
  .i_accel, .i_mode, .i_ref_speed, .o_ack, .o_err, .o_save_busy, .o_pass_is_default,
  .o_speed_cmd, .o_phase);
`default_nettype wire

//--- test/motor_limits_tb.sv
// self-checking bench for the current and speed limit stage
`timescale 1ns/100ps
`default_nettype none
module motor_limits_tb;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic stage_on = 1'b0;
  logic moving = 1'b0;
  logic accel = 1'b0;
  logic pass_rst = 1'b0;
  logic pass_chg = 1'b0;
  logic ce = 1'b1; // clock enable, dropped once to prove the freeze
  logic [15:0] mode = limit_pkg::MODE_PROF_POS;
  logic [15:0] ref_spd = 16'h0000;
  logic [15:0] nom = 16'h0100;
  logic wr, rd, save, ack, err, busy, pdef;
  logic [15:0] addr, wdata, rdata, spd, cur;
  logic [1:0] phase;
  logic [17:0] e;
  logic [17:0] exp_q[$]; // oldest note first: {read, err, data}
  logic [15:0] pct[3];
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam logic [15:0] PADDR[3] = '{16'h1414, 16'h1416, 16'h1418};
  localparam logic [15:0] MODES[6] = '{16'hFFFF, 16'h0001, 16'h0003, 16'h0006, 16'h0008, 16'h0000};

  always #5 i_mclk = ~i_mclk;

  motor_limits motor_limits_i (.i_mclk, .i_rst, .i_ce(ce), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wdata), .i_save(save), .i_pass_restore(pass_rst),
    .o_rdata(rdata), .o_ack(ack), .o_err(err), .o_save_busy(busy),
    .o_pass_is_default(pdef), .i_stage_on(stage_on), .i_moving(moving), .i_accel(accel),
    .i_mode(mode), .i_ref_speed(ref_spd), .i_nominal_motor_current(nom),
    .i_pass_change(pass_chg), .o_speed_cmd(spd), .o_current_limit(cur), .o_phase(phase));
  param_master param_master_i (.i_mclk, .o_wr(wr), .o_rd(rd), .o_save(save),
    .o_addr(addr), .o_wdata(wdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task automatic test_done();
  begin
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask

  // driver notes the answer, then the master makes the access
  task automatic acc(input logic r, input logic [15:0] a, input logic [15:0] d, input logic x);
  begin
    exp_q.push_back({r, x, d});
    param_master_i.access(r, a, d);
  end
  endtask

  task automatic settle();
  begin
    repeat (3) @(posedge i_mclk);
    #1;
  end
  endtask

  // one-cycle password strobe: restore when r is set, user change otherwise
  task automatic pulse(input logic r);
  begin
    pass_rst = r;
    pass_chg = !r;
    @(posedge i_mclk);
    #1;
    pass_rst = 1'b0;
    pass_chg = 1'b0;
    settle();
  end
  endtask

  // percent of nominal, worked in 32 bits so the product cannot wrap
  function automatic logic [15:0] cl(input logic [15:0] p);
    return 16'((32'(p) * 32'(nom)) / 32'h64);
  endfunction

  // answer monitor: each answer consumes the oldest note
  // sampled on the falling edge so the answer launched at the rising edge has settled
  always @(negedge i_mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      test_done();
    end
    if (ack === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 18'h3FFFF;
      chk({15'h0000, err}, {15'h0000, e[16]});
      if (e[17])
        chk(rdata, e[15:0]);
    end
  end

  initial
  begin
    void'($urandom(25));
    nom = 16'(200 + $urandom_range(399));
    repeat (20) @(posedge i_mclk);
    #1;
    i_rst = 1'b0;
    acc(1'b1, limit_pkg::ADDR_SPEED_CEIL, limit_pkg::RST_SPEED_CEIL, 1'b0);
    acc(1'b1, PADDR[0], limit_pkg::RST_STAND_PCT, 1'b0);
    acc(1'b1, PADDR[1], limit_pkg::RST_RAMP_PCT, 1'b0);
    acc(1'b1, PADDR[2], limit_pkg::RST_CRUISE_PCT, 1'b0);
    settle();
    chk(cur, cl(limit_pkg::RST_STAND_PCT));
    // request far above any legal ceiling while the reset ceiling is in force
    ref_spd = 16'hFFFF;
    settle();
    chk(spd, limit_pkg::RST_SPEED_CEIL);
    for (int i = 0; i < 3; i++)
    begin
      pct[i] = 16'($urandom_range(100, 1));
      acc(1'b0, PADDR[i], 16'h0001, 1'b0);
      acc(1'b0, PADDR[i], pct[i], 1'b0);
      acc(1'b0, PADDR[i], 16'h0000, 1'b1);
      acc(1'b0, PADDR[i], 16'h0065, 1'b1);
      acc(1'b1, PADDR[i], pct[i], 1'b0);
    end
    acc(1'b0, 16'h1420, 16'h0001, 1'b1);
    // a write while the enable is low is neither taken nor answered
    ce = 1'b0;
    param_master_i.access(1'b0, PADDR[0], (pct[0] == 16'h0032) ? 16'h0033 : 16'h0032);
    ce = 1'b1;
    acc(1'b1, PADDR[0], pct[0], 1'b0);
    settle();
    chk(cur, cl(pct[0]));
    accel = 1'b1;
    moving = 1'b1;
    settle();
    chk(cur, cl(pct[1]));
    chk({14'h0000, phase}, {14'h0000, limit_pkg::PH_RAMP});
    accel = 1'b0;
    settle();
    chk(cur, cl(pct[2]));
    chk({14'h0000, phase}, {14'h0000, limit_pkg::PH_CRUISE});
    acc(1'b0, PADDR[2], 16'h0064, 1'b0);
    settle();
    chk(cur, nom);
    moving = 1'b0;
    stage_on = 1'b1;
    acc(1'b0, limit_pkg::ADDR_SPEED_CEIL, 16'h03E8, 1'b1);
    stage_on = 1'b0;
    acc(1'b0, limit_pkg::ADDR_SPEED_CEIL, 16'h003B, 1'b1);
    acc(1'b0, limit_pkg::ADDR_SPEED_CEIL, 16'h03E8, 1'b0);
    ref_spd = 16'h1388;
    mode = limit_pkg::MODE_PROF_VEL;
    settle();
    chk(spd, 16'h1388);
    moving = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      mode = MODES[i];
      settle();
      chk(spd, (i < 4) ? 16'h03E8 : 16'h1388);
    end
    moving = 1'b0;
    param_master_i.save();
    chk({15'h0000, busy}, 16'h0001);
    for (int k = 0; k < 10 && busy !== 1'b0; k++)
    begin
      @(posedge i_mclk);
      #1;
    end
    chk({15'h0000, busy}, 16'h0000);
    pulse(1'b0);
    chk({15'h0000, pdef}, 16'h0000);
    pulse(1'b1);
    chk({15'h0000, pdef}, 16'h0001);
    settle();
    chk(16'(exp_q.size()), 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
